// >>> verilog/sdc_pkg.sv
// Shared constants for the serial converter command link
package sdc_pkg;

  // Frame layout, sent most significant bit first
  localparam int FRAME_W = 16;
  localparam int CMD_W = 3;
  localparam int CODE_W = 10;
  localparam int SUB_W = 3;
  localparam int CMD_LSB = 13;
  localparam int CODE_LSB = 3;
  localparam int SUB_LSB = 0;
  localparam int BYTE_W = 8;

  // Bit counter saturates one past a full frame
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_SAT = 5'h11;

  // Low two command bits pick the operation; top bit splits the last pair
  localparam int OP_W = 2;
  localparam logic [OP_W-1:0] OP_LOAD_UPDATE = 2'h0;
  localparam logic [OP_W-1:0] OP_LOAD = 2'h1;
  localparam logic [OP_W-1:0] OP_RECALL = 2'h2;
  localparam logic [OP_W-1:0] OP_SPECIAL = 2'h3;
  localparam int CMD_TOP = 2;

  // Reset and fill values
  localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
  localparam logic [SUB_W-1:0] SUB_ZERO = 3'h0;
  localparam logic [CMD_W-1:0] CMD_RST = 3'h3;

  // Link timing in ns and derived system-clock counts (least times round up)
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCLK_MIN_PERIOD_NS = 100;
  localparam int T_CSS_NS = 40;
  localparam int T_CSW_NS = 100;
  localparam int SCLK_HALF_CYC =
    (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int CSS_CYC = (T_CSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSW_CYC = (T_CSW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;

endpackage : sdc_pkg

// >>> verilog/sdc_link_if.sv
// Three-wire write-only link between host and converter front end
`timescale 1ns/100ps
interface sdc_link_if;
  logic cs_n;
  logic din;
  logic sclk;

  // Host drives all three wires
  modport host (
    output cs_n,
    output din,
    output sclk
  );

  // Converter only listens
  modport dev (
    input cs_n,
    input din,
    input sclk
  );
endinterface : sdc_link_if

// >>> verilog/sdc_host.sv
// Host end: turns command requests into serial frames on the link
`timescale 1ns/100ps
module sdc_host #(
  parameter int HALF_CYCLES = sdc_pkg::SCLK_HALF_CYC
) (
  // System clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Command request
  input wire logic i_valid,
  input wire logic [sdc_pkg::CMD_W-1:0] i_cmd,
  input wire logic [sdc_pkg::CODE_W-1:0] i_code,
  input wire logic i_split,
  output logic o_ready,
  output logic o_done,
  // Serial link
  sdc_link_if.host link
);

  localparam int TW = sdc_pkg::TMR_W;
  localparam int BW = $clog2(sdc_pkg::FRAME_W);
  localparam logic [TW-1:0] HALF_LD = TW'(HALF_CYCLES - 1);
  localparam logic [TW-1:0] CSS_LD = TW'(sdc_pkg::CSS_CYC - 1);
  localparam logic [TW-1:0] CSW_LD = TW'(sdc_pkg::CSW_CYC - 1);
  localparam logic [BW-1:0] LAST_IDX = BW'(sdc_pkg::FRAME_W - 1);
  localparam logic [BW-1:0] MID_IDX = BW'(sdc_pkg::BYTE_W - 1);

  // A shorter half period would break the link's top clock rate
  if (HALF_CYCLES < sdc_pkg::SCLK_HALF_CYC || HALF_CYCLES > (1 << TW)) begin : g_bad_half
    $error("HALF_CYCLES outside what the link and timer allow");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH,
    ST_GAP,
    ST_HOLD,
    ST_REST
  } sdc_host_state_type;

  sdc_host_state_type state_q, state_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic [BW-1:0] bit_q, bit_d;
  logic [sdc_pkg::FRAME_W-1:0] word_q, word_d;
  logic split_q, split_d;
  logic cs_n_q, cs_n_d;
  logic sclk_q, sclk_d;
  logic din_q, din_d;
  logic done_q, done_d;

  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q;
    bit_d = bit_q;
    word_d = word_q;
    split_d = split_q;
    cs_n_d = cs_n_q;
    sclk_d = sclk_q;
    din_d = din_q;
    done_d = 1'b0;
    if (tmr_q != '0) begin
      tmr_d = tmr_q - 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (i_valid) begin
            word_d = {i_cmd, i_code, sdc_pkg::SUB_ZERO};
            din_d = i_cmd[sdc_pkg::CMD_W-1];
            split_d = i_split;
            bit_d = '0;
            cs_n_d = 1'b0;
            tmr_d = CSS_LD;
            state_d = ST_SETUP;
          end
        end
        ST_SETUP, ST_LOW: begin
          sclk_d = 1'b1;
          tmr_d = HALF_LD;
          state_d = ST_HIGH;
        end
        ST_HIGH: begin
          sclk_d = 1'b0;
          tmr_d = HALF_LD;
          word_d = word_q << 1;
          din_d = word_q[sdc_pkg::FRAME_W-2];
          bit_d = bit_q + 1'b1;
          if (bit_q == LAST_IDX) begin
            state_d = ST_HOLD;
          end else if (split_q && bit_q == MID_IDX) begin
            state_d = ST_GAP;
          end else begin
            state_d = ST_LOW;
          end
        end
        ST_GAP: begin
          // Select stays low across the byte gap
          tmr_d = HALF_LD;
          state_d = ST_LOW;
        end
        ST_HOLD: begin
          cs_n_d = 1'b1;
          done_d = 1'b1;
          tmr_d = CSW_LD;
          state_d = ST_REST;
        end
        ST_REST: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
      bit_q <= '0;
      word_q <= '0;
      split_q <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      din_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      bit_q <= bit_d;
      word_q <= word_d;
      split_q <= split_d;
      cs_n_q <= cs_n_d;
      sclk_q <= sclk_d;
      din_q <= din_d;
      done_q <= done_d;
    end
  end

  assign o_ready = (state_q == ST_IDLE);
  assign o_done = done_q;
  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.din = din_q;

endmodule : sdc_host

// >>> verilog/sdc_device.sv
// Device end: serial command front end of a 10-bit converter
`timescale 1ns/100ps
// Operation
// - 16 bits, MSB first: command, code, sub-bits
// - Host keeps select low for all sixteen bits
// - Host sends sub-bits as zero
// - Select high: interface disabled, clocks ignored
// - Select low: shift data on rising clock
// - Host lowers select before first rising clock
// - Host keeps serial clock within maximum rate
// - Registers change only at select rising edge
// - Command x00: load both registers, leave shutdown
// - Command x01: load input register only
// - Command x10: copy input to converter, wake
// - Command 111: enter shutdown
// - Command 011: no operation
// - Interface keeps decoding frames during shutdown
// - Input register kept; recall or load-both (x00) wakes, load x01 does not
// - Code is plain unsigned binary, 0 to 1023
// - Power-up clears input and converter registers
module sdc_device (
  // System clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Serial link
  sdc_link_if.dev link,
  // Converter side
  output logic [sdc_pkg::CODE_W-1:0] o_code,
  output logic [sdc_pkg::CODE_W-1:0] o_input_code,
  output logic o_shutdown,
  // Frame status
  output logic o_frame_done,
  output logic o_frame_error,
  output logic [sdc_pkg::CMD_W-1:0] o_last_cmd,
  output logic [sdc_pkg::SUB_W-1:0] o_last_sub
);

  localparam int FW = sdc_pkg::FRAME_W;
  localparam int NW = sdc_pkg::CNT_W;
  localparam int SW = NW + FW;

  // The decode slices assume the three fields tile the frame and that
  // the bit counter can count one past a full frame without wrapping
  if (sdc_pkg::CMD_W + sdc_pkg::CODE_W + sdc_pkg::SUB_W != FW ||
      sdc_pkg::CMD_LSB != sdc_pkg::CODE_LSB + sdc_pkg::CODE_W ||
      sdc_pkg::CNT_FULL != NW'(FW) ||
      sdc_pkg::CNT_SAT <= sdc_pkg::CNT_FULL) begin : g_bad_layout
    $error("frame layout constants do not fit the decode");
  end

  // Link domain, clocked by the serial clock

  logic [NW-1:0] bits_q, bits_d;
  logic [FW-1:0] shift_q, shift_d;
  logic [SW-1:0] snap_q, snap_d;

  always_comb begin
    shift_d = {shift_q[FW-2:0], link.din};
    bits_d = bits_q;
    // Saturation keeps an overlong frame from wrapping back to sixteen
    if (bits_q != sdc_pkg::CNT_SAT) begin
      bits_d = bits_q + 1'b1;
    end
  end

  // Select high holds the shifter cleared, so clocks then change nothing
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bits_q <= '0;
      shift_q <= '0;
    end else begin
      bits_q <= bits_d;
      shift_q <= shift_d;
    end
  end

  // The select edge itself latches the frame, before the clear above lands
  always_comb begin
    snap_d = {bits_q, shift_q};
  end

  always_ff @(posedge link.cs_n) begin
    snap_q <= snap_d;
  end

  // System domain
  // Select high must last two system clocks to be seen; the link's
  // minimum select gap is well above that

  logic cs_meta_q, cs_meta_d;
  logic cs_sync_q, cs_sync_d;
  logic cs_prev_q, cs_prev_d;
  logic cs_rise;

  always_comb begin
    cs_meta_d = link.cs_n;
    cs_sync_d = cs_meta_q;
    cs_prev_d = cs_sync_q;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      cs_meta_q <= cs_meta_d;
      cs_sync_q <= cs_sync_d;
      cs_prev_q <= cs_prev_d;
    end
  end

  // Snapshot is quiet from the select edge until the next one, so it is
  // safe to read once the synchronised edge shows up here
  assign cs_rise = cs_sync_q & ~cs_prev_q;

  logic [NW-1:0] snap_bits;
  logic [sdc_pkg::CMD_W-1:0] snap_cmd;
  logic [sdc_pkg::CODE_W-1:0] snap_code;
  logic [sdc_pkg::SUB_W-1:0] snap_sub;
  logic frame_ok;

  // Code field taken as plain unsigned binary
  assign snap_bits = snap_q[FW +: NW];
  assign snap_cmd = snap_q[sdc_pkg::CMD_LSB +: sdc_pkg::CMD_W];
  assign snap_code = snap_q[sdc_pkg::CODE_LSB +: sdc_pkg::CODE_W];
  assign snap_sub = snap_q[sdc_pkg::SUB_LSB +: sdc_pkg::SUB_W];
  assign frame_ok = (snap_bits == sdc_pkg::CNT_FULL);

  logic [sdc_pkg::CODE_W-1:0] input_q, input_d;
  logic [sdc_pkg::CODE_W-1:0] conv_q, conv_d;
  logic shdn_q, shdn_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic [sdc_pkg::CMD_W-1:0] lcmd_q, lcmd_d;
  logic [sdc_pkg::SUB_W-1:0] lsub_q, lsub_d;

  always_comb begin
    input_d = input_q;
    conv_d = conv_q;
    shdn_d = shdn_q;
    done_d = 1'b0;
    err_d = 1'b0;
    lcmd_d = lcmd_q;
    lsub_d = lsub_q;
    // Decoding runs the same way in shutdown as out of it
    if (cs_rise) begin
      if (!frame_ok) begin
        err_d = 1'b1;
      end else begin
        done_d = 1'b1;
        lcmd_d = snap_cmd;
        lsub_d = snap_sub;
        unique case (snap_cmd[sdc_pkg::OP_W-1:0])
          sdc_pkg::OP_LOAD_UPDATE: begin
            input_d = snap_code;
            conv_d = snap_code;
            shdn_d = 1'b0;
          end
          sdc_pkg::OP_LOAD: begin
            input_d = snap_code;
          end
          sdc_pkg::OP_RECALL: begin
            conv_d = input_q;
            shdn_d = 1'b0;
          end
          sdc_pkg::OP_SPECIAL: begin
            if (snap_cmd[sdc_pkg::CMD_TOP]) begin
              shdn_d = 1'b1;
            end else begin
              // Top bit clear is no_operation; input, converter and shutdown state hold
              shdn_d = shdn_q;
            end
          end
        endcase
      end
    end
  end

  // Input register is never touched by shutdown itself
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      input_q <= sdc_pkg::CODE_RST;
      conv_q <= sdc_pkg::CODE_RST;
      shdn_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      lcmd_q <= sdc_pkg::CMD_RST;
      lsub_q <= sdc_pkg::SUB_ZERO;
    end else begin
      input_q <= input_d;
      conv_q <= conv_d;
      shdn_q <= shdn_d;
      done_q <= done_d;
      err_q <= err_d;
      lcmd_q <= lcmd_d;
      lsub_q <= lsub_d;
    end
  end

  assign o_code = conv_q;
  assign o_input_code = input_q;
  assign o_shutdown = shdn_q;
  assign o_frame_done = done_q;
  assign o_frame_error = err_q;
  assign o_last_cmd = lcmd_q;
  assign o_last_sub = lsub_q;

endmodule : sdc_device

// >>> verif/sdc_link_sva.sv
// Wire-level checks on the host-to-converter link
`timescale 1ns/100ps
module sdc_link_sva (
  // System domain
  input wire logic i_clock,
  input wire logic i_reset,
  // Link wires
  input wire logic cs_n,
  input wire logic din,
  input wire logic sclk
);
  logic sclk_q;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [2:0] sh_q;
  logic [2:0] sh_d;

  // Bits per frame and the last three seen
  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    if (cs_n) begin
      cnt_d = 5'h00;
    end else if (sclk && !sclk_q) begin
      cnt_d = cnt_q + 5'h01;
      sh_d = {sh_q[1:0], din};
    end
  end

  always_ff @(posedge i_clock) begin
    sclk_q <= sclk;
    cnt_q <= cnt_d;
    sh_q <= sh_d;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  property p_sclk_idle; cs_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock high while deselected");
  property p_first_rise; $fell(cs_n) |-> !sclk[*8] ##[0:4] sclk; endproperty
  a_first_rise: assert property (p_first_rise)
    else $error("first clock rise too early or missing");
  property p_high_w; $rose(sclk) |-> sclk[*8]; endproperty
  a_high_w: assert property (p_high_w)
    else $error("serial clock high phase short");
  property p_low_w; $fell(sclk) |-> !sclk[*8]; endproperty
  a_low_w: assert property (p_low_w)
    else $error("serial clock low phase short");
  property p_din_setup; $rose(sclk) |-> din == $past(din, 8); endproperty
  a_din_setup: assert property (p_din_setup)
    else $error("data not settled before clock rise");
  property p_cs_gap; $rose(cs_n) |-> cs_n[*8] ##1 cs_n[*8] ##1 cs_n[*4]; endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("select high gap short");
  property p_bits; $rose(cs_n) |-> cnt_q == 5'h10; endproperty
  a_bits: assert property (p_bits)
    else $error("frame not sixteen bits");
  property p_sub; $rose(cs_n) |-> sh_q == 3'h0; endproperty
  a_sub: assert property (p_sub)
    else $error("sub-bits not zero");
endmodule : sdc_link_sva

// >>> verif/serial_dac_command_interface_tb.sv
// Bench: host and converter joined, plus a hand-driven faulty link
`timescale 1ns/100ps
module serial_dac_command_interface_tb;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_valid = 1'b0;
  logic [2:0] i_cmd = 3'h0;
  logic [9:0] i_code = 10'h000;
  logic i_split = 1'b0;
  logic o_ready, o_done, sd, fd, fe, sd2, fd2, fe2;
  logic [9:0] cd, ic, cd2, ic2;
  logic [2:0] lc, ls, lc2, ls2;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int dn = 0;
  int er2 = 0;
  int dn2 = 0;
  int hd = 0;
  int er = 0;

  sdc_link_if lk ();
  sdc_link_if lk2 ();
  sdc_host u_sdc_host (.i_clock(i_clock), .i_reset(i_reset), .i_valid(i_valid),
    .i_cmd(i_cmd), .i_code(i_code), .i_split(i_split), .o_ready(o_ready),
    .o_done(o_done), .link(lk));
  sdc_device u_sdc_device (.i_clock(i_clock), .i_reset(i_reset), .link(lk), .o_code(cd),
    .o_input_code(ic), .o_shutdown(sd), .o_frame_done(fd), .o_frame_error(fe),
    .o_last_cmd(lc), .o_last_sub(ls));
  sdc_device u_sdc_device_2 (.i_clock(i_clock), .i_reset(i_reset), .link(lk2),
    .o_code(cd2), .o_input_code(ic2), .o_shutdown(sd2), .o_frame_done(fd2),
    .o_frame_error(fe2), .o_last_cmd(lc2), .o_last_sub(ls2));
  sdc_link_sva u_sva (.i_clock(i_clock), .i_reset(i_reset), .cs_n(lk.cs_n),
    .din(lk.din), .sclk(lk.sclk));

  always #2.5 i_clock = ~i_clock;

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    dn <= dn + int'(fd === 1'b1);
    dn2 <= dn2 + int'(fd2 === 1'b1);
    hd <= hd + int'(o_done === 1'b1);
    er <= er + int'(fe === 1'b1);
    er2 <= er2 + int'(fe2 === 1'b1);
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // One host request, then wait for the decoded frame
  task automatic send(input logic [2:0] c, input logic [9:0] d, input logic s);
    int n;
    int h;
    n = dn;
    h = hd;
    while (o_ready !== 1'b1) begin
      @(posedge i_clock);
      #1;
    end
    i_valid = 1'b1;
    i_cmd = c;
    i_code = d;
    i_split = s;
    @(posedge i_clock);
    #1;
    i_valid = 1'b0;
    for (int k = 0; k < 500 && dn == n; k++) @(posedge i_clock);
    #1;
    chk(10'(dn - n), 10'h001);
    chk(10'(hd - h), 10'h001);
    chk({7'h00, lc}, {7'h00, c});
    chk({7'h00, ls}, 10'h000);
  endtask : send

  // Three checks of the converter state
  task automatic expect3(input logic [9:0] c, input logic [9:0] i, input logic s);
    chk(cd, c);
    chk(ic, i);
    chk_bit(sd, s);
  endtask : expect3

  // Hand-made frame of nb bits on the second link, MSB first
  task automatic bang(input logic [16:0] w, input int nb);
    lk2.cs_n = 1'b0;
    for (int k = nb - 1; k >= 0; k--) begin
      lk2.din = w[k];
      #40 lk2.sclk = 1'b1;
      #40 lk2.sclk = 1'b0;
    end
    #40 lk2.cs_n = 1'b1;
    lk2.din = ~lk2.din;
    #400;
  endtask : bang

  task automatic t_cmds;
    expect3(10'h000, 10'h000, 1'b0);
    send(3'h0, 10'h3ff, 1'b0);
    expect3(10'h3ff, 10'h3ff, 1'b0);
    send(3'h4, 10'h201, 1'b1);
    expect3(10'h201, 10'h201, 1'b0);
    send(3'h1, 10'h155, 1'b0);
    expect3(10'h201, 10'h155, 1'b0);
    send(3'h5, 10'h2aa, 1'b1);
    expect3(10'h201, 10'h2aa, 1'b0);
    send(3'h7, 10'h000, 1'b0);
    expect3(10'h201, 10'h2aa, 1'b1);
    send(3'h3, 10'h0f0, 1'b0);
    expect3(10'h201, 10'h2aa, 1'b1);
    send(3'h2, 10'h0f0, 1'b0);
    expect3(10'h2aa, 10'h2aa, 1'b0);
    send(3'h7, 10'h000, 1'b0);
    send(3'h1, 10'h0c3, 1'b0);
    expect3(10'h2aa, 10'h0c3, 1'b1);
    send(3'h6, 10'h000, 1'b1);
    expect3(10'h0c3, 10'h0c3, 1'b0);
    send(3'h7, 10'h000, 1'b0);
    send(3'h0, 10'h05a, 1'b0);
    expect3(10'h05a, 10'h05a, 1'b0);
    chk(10'(er), 10'h000);
    $display("test commands done");
  endtask : t_cmds

  task automatic t_wire;
    // Clocks while deselected must not shift anything in
    for (int k = 0; k < 16; k++) begin
      lk2.din = k[0];
      #40 lk2.sclk = 1'b1;
      #40 lk2.sclk = 1'b0;
    end
    bang(17'h007f8, 16);
    chk(cd2, 10'h0ff);
    chk({7'h00, lc2}, 10'h000);
    chk({7'h00, ls2}, 10'h000);
    bang(17'h03ff0, 15);
    bang(17'h0fff0, 17);
    chk(10'(er2), 10'h002);
    chk(10'(dn2), 10'h001);
    chk(ic2, 10'h0ff);
    chk(cd2, 10'h0ff);
    chk_bit(sd2, 1'b0);
    chk({7'h00, lc2}, 10'h000);
    $display("test link faults done");
  endtask : t_wire

  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    lk2.cs_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.din = 1'b0;
    repeat (8) @(posedge i_clock);
    #1;
    i_reset = 1'b0;
    t_cmds();
    t_wire();
    report_and_stop();
  end
endmodule : serial_dac_command_interface_tb
